// file: design/bfp_regs.svh
// register map, field positions, reset values and timing counts
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH
//----------------------------------------------------------------
// register byte offsets
//----------------------------------------------------------------
`define BFP_CTRL 8'h00
`define BFP_BF_CFG 8'h04
`define BFP_BF_DELAY 8'h08
`define BFP_PRG_CFG 8'h0C
`define BFP_PRG_PICKUP 8'h10
`define BFP_PRG_HYST 8'h14
`define BFP_PRG_FLOOR 8'h18
`define BFP_PRG_DELAY 8'h1C
`define BFP_STATUS 8'h20
`define BFP_BF_CNT 8'h24
`define BFP_PRG_CNT 8'h28
`define BFP_REC_SEL 8'h2C
`define BFP_REC_DATE 8'h30
`define BFP_REC_TIME 8'h34
`define BFP_REC_MSEC 8'h38
`define BFP_REC_ELAPSED_DELAY_PERCENT 8'h3C
//----------------------------------------------------------------
// field positions
//----------------------------------------------------------------
`define BFP_CTRL_FORCE 0
`define BFP_CTRL_FSTG_LSB 1
`define BFP_CTRL_CLR_LSB 8
`define BFP_CFG_SEL_A_LSB 0
`define BFP_CFG_SEL_B_LSB 8
`define BFP_CFG_MODE_LSB 16
`define BFP_CFG_IV_LSB 20
`define BFP_CFG_EN 24
//----------------------------------------------------------------
// reset values
//----------------------------------------------------------------
`define BFP_BF_DELAY_RST 16'h00C8
`define BFP_PRG_DELAY_RST 16'h0064
`define BFP_PICKUP_RST 16'h0000
`define BFP_HYST_RST 16'h0000
`define BFP_FLOOR_RST 16'h0000
//----------------------------------------------------------------
// sizes and timing
//----------------------------------------------------------------
`define BFP_NUM_STAGES 2
`define BFP_NUM_REC 8
`define BFP_SIG_COUNT 45
`define BFP_HARMONIC_DISTORTION_VALUE_FIRST 31
`define BFP_VIRTUAL_ANALOG_INPUT_FIRST 40
`define BFP_CLK_KHZ 25000
`define BFP_TICK_MS 1
`define BFP_FORCE_MIN 5
`define BFP_MS_PER_MIN 60000
`define BFP_IV_10 7'h0A
`define BFP_IV_20 7'h14
`define BFP_IV_100 7'h64
`define BFP_PCT_FULL 8'h64
`endif

// file: design/bfp_pkg.sv
// types shared by the protection stage design
package bfp_pkg;
  typedef enum logic [1:0] {bfp_idle, bfp_blocked, bfp_started, bfp_tripped} bfp_status_t;
  typedef enum logic [1:0] {bfp_over, bfp_under, bfp_diff, bfp_magnitude_difference_mode}
    bfp_mode_t;
  typedef enum logic [1:0] {bfp_iv_10ms, bfp_iv_20ms, bfp_iv_100ms} bfp_interval_t;
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
    logic [15:0] msec;
  } bfp_stamp_t;
  typedef struct packed {
    bfp_stamp_t stamp;
    logic [7:0] elapsed_delay_percent;
  } bfp_record_t;
endpackage

// file: design/bfp_stage.sv
// one protection stage: delay timer, status, counters, elapsed delay
`timescale 1ns/1ps
`include "bfp_regs.svh"
module bfp_stage
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic [6:0] step,
  input wire logic cond,
  input wire logic blocked,
  input wire logic [15:0] delay_ms,
  input wire logic force_start,
  input wire logic force_trip,
  input wire logic clr_start,
  input wire logic clr_trip,
  output bfp_pkg::bfp_status_t status,
  output logic started,
  output logic tripped,
  output logic [15:0] start_event_counter,
  output logic [15:0] trip_event_counter,
  output logic rec_we,
  output logic [7:0] rec_elapsed_delay_percent
);
  logic live;
  logic timer_done;
  logic [16:0] elapsed;
  logic [16:0] next_elapsed;
  logic [23:0] pct_acc;
  logic [7:0] pct;
  logic next_started;
  logic next_tripped;

  // live condition and forced overrides
  assign live = cond & ~blocked;
  assign next_elapsed = elapsed + {10'h000, step};
  assign next_tripped = (live & timer_done) | force_trip;
  assign next_started = live | force_start | next_tripped;

  // definite delay timer, restarts whenever the condition drops
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      elapsed <= '0;
      timer_done <= 1'b0;
    end
    else if (!live)
    begin
      elapsed <= '0;
      timer_done <= 1'b0;
    end
    else if (tick && !timer_done)
    begin
      elapsed <= next_elapsed;
      timer_done <= (next_elapsed >= {1'b0, delay_ms});
    end
  end

  // elapsed delay as percent of setting, by repeated subtraction
  always_ff @(posedge clock)
  begin
    if (!reset_n || !live)
    begin
      pct_acc <= '0;
      pct <= '0;
    end
    else if (timer_done)
      pct <= `BFP_PCT_FULL;
    else if (tick)
      pct_acc <= pct_acc + 24'(`BFP_PCT_FULL) * 24'(step);
    else if (delay_ms != 16'h0000 && pct_acc >= {8'h00, delay_ms}
             && pct < `BFP_PCT_FULL - 8'h01)
    begin
      pct <= pct + 8'h01;
      pct_acc <= pct_acc - {8'h00, delay_ms};
    end
  end

  // present status
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      started <= 1'b0;
      tripped <= 1'b0;
      status <= bfp_pkg::bfp_idle;
    end
    else
    begin
      started <= next_started;
      tripped <= next_tripped;
      if (next_tripped)
        status <= bfp_pkg::bfp_tripped;
      else if (next_started)
        status <= bfp_pkg::bfp_started;
      else if (blocked)
        status <= bfp_pkg::bfp_blocked;
      else
        status <= bfp_pkg::bfp_idle;
    end
  end

  // cumulative counters, a new event beats a clear
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      start_event_counter <= '0;
      trip_event_counter <= '0;
    end
    else
    begin
      if (next_started && !started)
        start_event_counter <= clr_start ? 16'h0001 : start_event_counter + 16'h0001;
      else if (clr_start)
        start_event_counter <= '0;
      if (next_tripped && !tripped)
        trip_event_counter <= clr_trip ? 16'h0001 : trip_event_counter + 16'h0001;
      else if (clr_trip)
        trip_event_counter <= '0;
    end
  end

  // one record request at the end of each fault
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rec_we <= 1'b0;
      rec_elapsed_delay_percent <= '0;
    end
    else
    begin
      rec_we <= started & ~next_started;
      rec_elapsed_delay_percent <= pct;
    end
  end
endmodule

// file: design/bfp_top.sv
// breaker failure and programmable protection stages behind wishbone
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bfp_regs.svh"
//----------------------------------------------------------------
//----------------------------------------------------------------
module bfp_top
#(
  parameter int TICK_CYCLES = `BFP_CLK_KHZ * `BFP_TICK_MS,
  parameter int FORCE_TICKS = `BFP_FORCE_MIN * `BFP_MS_PER_MIN / `BFP_TICK_MS,
  parameter int NSIG = `BFP_SIG_COUNT
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] trip_ctrl,
  input wire logic block_bf,
  input wire logic block_prg,
  input wire logic [NSIG-1:0][15:0] meas,
  input wire bfp_pkg::bfp_stamp_t rtc_stamp,
  output logic backup_relay,
  output logic cb_monitor_relay,
  output logic prg_start,
  output logic prg_trip,
  output logic force_active
);
  //----------------------------------------------------------------
  // parameter checks
  //----------------------------------------------------------------
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65536)
    $error("TICK_CYCLES out of range");
  if (FORCE_TICKS < 1 || FORCE_TICKS > 1048576)
    $error("FORCE_TICKS out of range");
  if (NSIG < 2 || NSIG > 64)
    $error("NSIG out of range");

  //----------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic [7:0] word_adr;
  logic [31:0] rd_image;
  logic [31:0] merged;
  logic [15:0] ms_cnt;
  logic ms_tick;
  logic [6:0] iv_cnt;
  logic [6:0] iv_len;
  logic eval_tick;
  logic [19:0] force_cnt;
  logic force_end;
  logic [3:0] force_bits;
  logic [3:0] clr_pulse;
  logic bf_sel;
  logic [15:0] bf_delay;
  logic [5:0] sel_a;
  logic [5:0] sel_b;
  bfp_pkg::bfp_mode_t prg_mode;
  logic [1:0] prg_iv;
  logic prg_en;
  logic [15:0] pickup;
  logic [15:0] hyst;
  logic [15:0] under_mode_floor;
  logic [15:0] prg_delay;
  logic [3:0] rec_sel;
  logic signed [17:0] sig_a;
  logic signed [17:0] sig_b;
  logic signed [17:0] sig_d;
  logic signed [17:0] q;
  logic signed [17:0] pk;
  logic signed [17:0] hy;
  logic signed [17:0] fl;
  logic prg_cond;
  logic [1:0] st_cond;
  logic [1:0] st_block;
  logic [1:0] st_tick;
  logic [6:0] st_step [`BFP_NUM_STAGES];
  logic [15:0] st_delay [`BFP_NUM_STAGES];
  bfp_pkg::bfp_status_t st_status [`BFP_NUM_STAGES];
  logic [1:0] st_start;
  logic [1:0] st_trip;
  logic [15:0] start_event_counter [`BFP_NUM_STAGES];
  logic [15:0] trip_event_counter [`BFP_NUM_STAGES];
  logic [1:0] st_rec_we;
  logic [7:0] st_elapsed_delay_percent [`BFP_NUM_STAGES];
  bfp_pkg::bfp_record_t rec_out [`BFP_NUM_STAGES];
  logic [1:0] rec_ok;
  bfp_pkg::bfp_record_t rec_cur;
  logic rec_cur_ok;

  // byte lane merge of write data into the present image
  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = din[i*8 +: 8];
    return res;
  endfunction

  //----------------------------------------------------------------
  // wishbone slave
  //----------------------------------------------------------------
  // request decode, one access per ack
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign merged = bmerge(rd_image, wb_dat_i, wb_sel_i);

  // register images, unmapped reads zero
  always_comb
  begin
    rec_cur = rec_out[rec_sel[3]];
    rec_cur_ok = rec_ok[rec_sel[3]];
    rd_image = '0;
    unique case (word_adr)
      `BFP_CTRL: rd_image = {27'h000_0000, force_bits, force_active};
      `BFP_BF_CFG: rd_image = {31'h0000_0000, bf_sel};
      `BFP_BF_DELAY: rd_image = {16'h0000, bf_delay};
      `BFP_PRG_CFG: rd_image = {7'h00, prg_en, 2'b00, prg_iv, 2'b00, prg_mode,
                                2'b00, sel_b, 2'b00, sel_a};
      `BFP_PRG_PICKUP: rd_image = {16'h0000, pickup};
      `BFP_PRG_HYST: rd_image = {16'h0000, hyst};
      `BFP_PRG_FLOOR: rd_image = {16'h0000, under_mode_floor};
      `BFP_PRG_DELAY: rd_image = {16'h0000, prg_delay};
      `BFP_STATUS: rd_image = {26'h000_0000, force_active, backup_relay,
                               st_status[1], st_status[0]};
      `BFP_BF_CNT: rd_image = {trip_event_counter[0], start_event_counter[0]};
      `BFP_PRG_CNT: rd_image = {trip_event_counter[1], start_event_counter[1]};
      `BFP_REC_SEL: rd_image = {28'h000_0000, rec_sel};
      `BFP_REC_DATE: rd_image = rec_cur_ok ? {rec_cur.stamp.year, rec_cur.stamp.month,
                                              rec_cur.stamp.day} : 32'h0000_0000;
      `BFP_REC_TIME: rd_image = rec_cur_ok ? {rec_cur.stamp.hour, rec_cur.stamp.minute,
                                              rec_cur.stamp.second, 8'h00} : 32'h0000_0000;
      `BFP_REC_MSEC: rd_image = rec_cur_ok ? {16'h0000, rec_cur.stamp.msec} : 32'h0000_0000;
      `BFP_REC_ELAPSED_DELAY_PERCENT: rd_image = rec_cur_ok ? {23'h00_0000, 1'b1,
                                              rec_cur.elapsed_delay_percent} : 32'h0000_0000;
      default: rd_image = '0;
    endcase
  end

  // ack one cycle after the request, read data with it
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_o <= rd_image;
    end
  end

  //----------------------------------------------------------------
  // configuration registers
  //----------------------------------------------------------------
  // breaker failure relay select and delay
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      bf_sel <= 1'b0;
      bf_delay <= `BFP_BF_DELAY_RST;
    end
    else if (bus_wr)
    begin
      if (word_adr == `BFP_BF_CFG)
        bf_sel <= merged[0];
      if (word_adr == `BFP_BF_DELAY)
        bf_delay <= merged[15:0];
    end
  end

  // programmable stage selection and mode
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sel_a <= '0;
      sel_b <= '0;
      prg_mode <= bfp_pkg::bfp_over;
      prg_iv <= '0;
      prg_en <= 1'b0;
    end
    else if (bus_wr && word_adr == `BFP_PRG_CFG)
    begin
      sel_a <= merged[`BFP_CFG_SEL_A_LSB +: 6];
      sel_b <= merged[`BFP_CFG_SEL_B_LSB +: 6];
      prg_mode <= bfp_pkg::bfp_mode_t'(merged[`BFP_CFG_MODE_LSB +: 2]);
      prg_iv <= merged[`BFP_CFG_IV_LSB +: 2];
      prg_en <= merged[`BFP_CFG_EN];
    end
  end

  // programmable stage limits and delay
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pickup <= `BFP_PICKUP_RST;
      hyst <= `BFP_HYST_RST;
      under_mode_floor <= `BFP_FLOOR_RST;
      prg_delay <= `BFP_PRG_DELAY_RST;
    end
    else if (bus_wr)
    begin
      if (word_adr == `BFP_PRG_PICKUP)
        pickup <= merged[15:0];
      if (word_adr == `BFP_PRG_HYST)
        hyst <= merged[15:0];
      if (word_adr == `BFP_PRG_FLOOR)
        under_mode_floor <= merged[15:0];
      if (word_adr == `BFP_PRG_DELAY)
        prg_delay <= merged[15:0];
    end
  end

  // record selection
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      rec_sel <= '0;
    else if (bus_wr && word_adr == `BFP_REC_SEL)
      rec_sel <= merged[3:0];
  end

  //----------------------------------------------------------------
  // force flag and counter clears
  //----------------------------------------------------------------
  assign force_end = force_active && ms_tick && force_cnt == 20'(FORCE_TICKS - 1);

  // shared force flag, a software write beats the timeout
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      force_active <= 1'b0;
      force_cnt <= '0;
    end
    else if (bus_wr && word_adr == `BFP_CTRL)
    begin
      force_active <= merged[`BFP_CTRL_FORCE];
      force_cnt <= '0;
    end
    else if (force_end)
    begin
      force_active <= 1'b0;
      force_cnt <= '0;
    end
    else if (force_active && ms_tick)
      force_cnt <= force_cnt + 20'h0_0001;
  end

  // forced start and trip, accepted only while forcing
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      force_bits <= '0;
    else if (!force_active || force_end)
      force_bits <= '0;
    else if (bus_wr && word_adr == `BFP_CTRL)
      force_bits <= merged[`BFP_CTRL_FSTG_LSB +: 4] & {4{merged[`BFP_CTRL_FORCE]}};
  end

  // self clearing counter clear strobes
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      clr_pulse <= '0;
    else if (bus_wr && word_adr == `BFP_CTRL)
      clr_pulse <= merged[`BFP_CTRL_CLR_LSB +: 4];
    else
      clr_pulse <= '0;
  end

  //----------------------------------------------------------------
  // time base
  //----------------------------------------------------------------
  // millisecond tick
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (ms_cnt == 16'(TICK_CYCLES - 1));
      ms_cnt <= (ms_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0000 : ms_cnt + 16'h0001;
    end
  end

  // evaluation interval length of the programmable stage
  always_comb
  begin
    unique case (bfp_pkg::bfp_interval_t'(prg_iv))
      bfp_pkg::bfp_iv_10ms: iv_len = `BFP_IV_10;
      bfp_pkg::bfp_iv_20ms: iv_len = `BFP_IV_20;
      bfp_pkg::bfp_iv_100ms: iv_len = `BFP_IV_100;
      default: iv_len = `BFP_IV_100;
    endcase
  end

  // evaluation tick
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      iv_cnt <= '0;
      eval_tick <= 1'b0;
    end
    else
    begin
      eval_tick <= ms_tick && iv_cnt >= iv_len - 7'h01;
      if (ms_tick)
        iv_cnt <= (iv_cnt >= iv_len - 7'h01) ? 7'h00 : iv_cnt + 7'h01;
    end
  end

  //----------------------------------------------------------------
  // programmable comparison
  //----------------------------------------------------------------
  // signal pick and compared quantity
  always_comb
  begin
    sig_a = '0;
    sig_b = '0;
    if (sel_a < 6'(NSIG))
      sig_a = 18'($signed(meas[sel_a]));
    if (sel_b < 6'(NSIG))
      sig_b = 18'($signed(meas[sel_b]));
    sig_d = sig_a - sig_b;
    unique case (prg_mode)
      bfp_pkg::bfp_over: q = sig_a;
      bfp_pkg::bfp_under: q = sig_a;
      bfp_pkg::bfp_diff: q = sig_d;
      bfp_pkg::bfp_magnitude_difference_mode: q = (sig_d < 0) ? -sig_d : sig_d;
    endcase
  end

  assign pk = 18'($signed(pickup));
  assign hy = $signed({2'b00, hyst});
  assign fl = 18'($signed(under_mode_floor));

  // start condition with dead band, evaluated once per interval
  always_ff @(posedge clock)
  begin
    if (!reset_n || !prg_en)
      prg_cond <= 1'b0;
    else if (eval_tick)
    begin
      if (prg_mode == bfp_pkg::bfp_under)
      begin
        if (q < fl)
          prg_cond <= 1'b0;
        else if (!prg_cond)
          prg_cond <= (q < pk);
        else
          prg_cond <= (q <= pk + hy);
      end
      else if (!prg_cond)
        prg_cond <= (q > pk);
      else
        prg_cond <= (q >= pk - hy);
    end
  end

  //----------------------------------------------------------------
  // stage wiring: 0 breaker failure, 1 programmable
  //----------------------------------------------------------------
  assign st_cond[0] = trip_ctrl[bf_sel];
  assign st_cond[1] = prg_cond;
  assign st_block = {block_prg, block_bf};
  assign st_tick = {eval_tick, ms_tick};
  assign st_step[0] = 7'(`BFP_TICK_MS);
  assign st_step[1] = iv_len;
  assign st_delay[0] = bf_delay;
  assign st_delay[1] = prg_delay;

  for (genvar g = 0; g < `BFP_NUM_STAGES; g++)
  begin : g_stage
    bfp_pkg::bfp_record_t mem [`BFP_NUM_REC];
    logic [2:0] wptr;
    logic [3:0] fill;

    bfp_stage u_stage
    (
      .clock(clock),
      .reset_n(reset_n),
      .tick(st_tick[g]),
      .step(st_step[g]),
      .cond(st_cond[g]),
      .blocked(st_block[g]),
      .delay_ms(st_delay[g]),
      .force_start(force_bits[2*g]),
      .force_trip(force_bits[2*g+1]),
      .clr_start(clr_pulse[2*g]),
      .clr_trip(clr_pulse[2*g+1]),
      .status(st_status[g]),
      .started(st_start[g]),
      .tripped(st_trip[g]),
      .start_event_counter(start_event_counter[g]),
      .trip_event_counter(trip_event_counter[g]),
      .rec_we(st_rec_we[g]),
      .rec_elapsed_delay_percent(st_elapsed_delay_percent[g])
    );

    // ring of the latest faults with time stamp
    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        wptr <= '0;
        fill <= '0;
      end
      else if (st_rec_we[g])
      begin
        mem[wptr] <= {rtc_stamp, st_elapsed_delay_percent[g]};
        wptr <= wptr + 3'h1;
        if (fill != 4'(`BFP_NUM_REC))
          fill <= fill + 4'h1;
      end
    end

    // index 0 is the newest record
    assign rec_out[g] = mem[wptr - 3'h1 - rec_sel[2:0]];
    assign rec_ok[g] = {1'b0, rec_sel[2:0]} < fill;
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  // backup relay is its own pin, never the supervised one
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      backup_relay <= 1'b0;
      prg_start <= 1'b0;
      prg_trip <= 1'b0;
    end
    else
    begin
      backup_relay <= st_trip[0];
      prg_start <= st_start[1];
      prg_trip <= st_trip[1];
    end
  end

  // relay choice shared with breaker monitoring
  assign cb_monitor_relay = bf_sel;
endmodule

// file: verif/bfp_relay_model.sv
// trip relay contacts seen by the block
`timescale 1ns/1ps
module bfp_relay_model
(
  input wire logic clock,
  input wire logic [1:0] coil_cmd,
  output logic [1:0] trip_ctrl = 2'b00
);
  // contacts follow the coil command one clock later, backup kept apart
  always_ff @(posedge clock)
    trip_ctrl <= coil_cmd;
endmodule

// file: verif/bfp_checker.sv
// port assertions for the protection stage block
`timescale 1ns/1ps
module bfp_checker
#(
  parameter int TICK_CYCLES = 10,
  parameter int FORCE_TICKS = 20
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [1:0] trip_ctrl,
  input wire logic backup_relay,
  input wire logic cb_monitor_relay,
  input wire logic prg_start,
  input wire logic prg_trip,
  input wire logic force_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic req;
  logic [31:0] fcnt;
  // bus request not yet answered
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // cycles the force flag has stood since the last write
  always_ff @(posedge clock)
    fcnt <= (!reset_n || !force_active || (req && wb_we_i)) ? 32'h0000_0000 : fcnt + 32'h0000_0001;
  sequence held_trip;
    trip_ctrl[cb_monitor_relay] [*3];
  endsequence
  sequence all_released;
    (trip_ctrl == 2'b00) [*4];
  endsequence
  a_ack_next: assert property (req |=> wb_ack_o) else $error("no ack");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i[7:6] != 2'b00
    |=> wb_dat_o == 32'h0000_0000) else $error("unmapped data");
  a_backup_cause: assert property ($rose(backup_relay)
    |-> $past(trip_ctrl[cb_monitor_relay], 3)) else $error("backup without trip");
  a_backup_hold: assert property (held_trip ##0 backup_relay
    |=> backup_relay) else $error("backup dropped early");
  a_backup_release: assert property (all_released |-> !backup_relay)
    else $error("backup stuck");
  a_prg_delay: assert property ($rose(prg_trip) && !force_active
    |-> $past(prg_start, 2)) else $error("trip without start");
  a_force_expire: assert property (force_active
    |-> fcnt < FORCE_TICKS * TICK_CYCLES + 32) else $error("force stuck");
endmodule
bind bfp_top bfp_checker #(.TICK_CYCLES(TICK_CYCLES), .FORCE_TICKS(FORCE_TICKS))
  bfp_checker_i (.clock, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .trip_ctrl, .backup_relay, .cb_monitor_relay, .prg_start, .prg_trip, .force_active);

// file: verif/bfp_top_tb.sv
// self-checking bench for the protection stage block
`timescale 1ns/1ps
`include "bfp_regs.svh"
module bfp_top_tb;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic [1:0] coil_cmd = 2'b00;
  logic [1:0] trip_ctrl;
  logic [44:0][15:0] meas = '0;
  logic wb_ack_o, backup_relay, cb_monitor_relay, prg_start, prg_trip, force_active;
  logic block_bf = 1'b0;
  logic block_prg = 1'b0;
  // calendar stamp latched into each fault record
  bfp_pkg::bfp_stamp_t rtc_stamp = 72'h07E8_0102_0C22_3800_7B;
  int num_errors = 0;
  int checks = 0;
  int n;
  // address beside expected read value after reset
  logic [39:0] rows [5] = '{40'h08_0000_00C8, 40'h1C_0000_0064, 40'h20_0000_0000,
    40'h24_0000_0000, 40'h40_0000_0000};
  always #20 clock = ~clock;
  bfp_top #(.TICK_CYCLES(10), .FORCE_TICKS(20)) bfp_top_i (.clock, .reset_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .trip_ctrl, .block_bf, .block_prg, .meas, .rtc_stamp,
    .backup_relay, .cb_monitor_relay, .prg_start, .prg_trip, .force_active);
  bfp_relay_model bfp_relay_model_i (.clock, .coil_cmd, .trip_ctrl);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // bounded wait for a level, a timeout ends the run
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 2000)
    begin
      num_errors++;
      conclude();
    end
  endtask
  // one classic wishbone cycle, read data taken at the ack edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wait_for(wb_ack_o, 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, rows[i][39:32], 32'h0000_0000);
      chk(rd, rows[i][31:0]);
    end
    $display("reset values done");
    // breaker failure on relay 2 with a 3 ms delay
    wb(1'b1, `BFP_BF_DELAY, 32'h0000_0003);
    wb(1'b1, `BFP_BF_CFG, 32'h0000_0001);
    chk({31'h0000_0000, cb_monitor_relay}, 32'h0000_0001);
    coil_cmd <= 2'b10;
    repeat (20) @(posedge clock);
    chk({31'h0000_0000, backup_relay}, 32'h0000_0000);
    wait_for(backup_relay, 1'b1);
    repeat (5) @(posedge clock);
    chk({31'h0000_0000, backup_relay}, 32'h0000_0001);
    coil_cmd <= 2'b00;
    wait_for(backup_relay, 1'b0);
    wb(1'b0, `BFP_BF_CNT, 32'h0000_0000);
    chk(rd, 32'h0001_0001);
    wb(1'b1, `BFP_REC_SEL, 32'h0000_0000);
    wb(1'b0, `BFP_REC_ELAPSED_DELAY_PERCENT, 32'h0000_0000);
    chk(rd, 32'h0000_0164);
    wb(1'b0, `BFP_REC_DATE, 32'h0000_0000);
    chk(rd, 32'h07E8_0102);
    wb(1'b0, `BFP_REC_TIME, 32'h0000_0000);
    chk(rd, 32'h0C22_3800);
    wb(1'b0, `BFP_REC_MSEC, 32'h0000_0000);
    chk(rd, 32'h0000_007B);
    wb(1'b1, `BFP_CTRL, 32'h0000_0300);
    wb(1'b0, `BFP_BF_CNT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("breaker failure done");
    // programmable over mode on signal 3, 30 ms delay
    wb(1'b1, `BFP_PRG_PICKUP, 32'h0000_0064);
    wb(1'b1, `BFP_PRG_DELAY, 32'h0000_001E);
    wb(1'b1, `BFP_PRG_CFG, 32'h0100_0003);
    meas[3] <= 16'h00C8;
    wait_for(prg_start, 1'b1);
    chk({31'h0000_0000, prg_trip}, 32'h0000_0000);
    wait_for(prg_trip, 1'b1);
    wb(1'b0, `BFP_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_000C);
    // under mode, values below the floor are no fault
    meas[3] <= 16'h0000;
    wb(1'b1, `BFP_PRG_FLOOR, 32'h0000_000A);
    wb(1'b1, `BFP_PRG_CFG, 32'h0101_0003);
    repeat (300) @(posedge clock);
    chk({31'h0000_0000, prg_start}, 32'h0000_0000);
    meas[3] <= 16'h0032;
    wait_for(prg_start, 1'b1);
    chk({31'h0000_0000, prg_start}, 32'h0000_0001);
    $display("programmable done");
    // forcing refused until the flag is on, then the flag clears itself
    meas[3] <= 16'h0000;
    wait_for(prg_start, 1'b0);
    wb(1'b1, `BFP_CTRL, 32'h0000_0009);
    chk({31'h0000_0000, force_active}, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, prg_start}, 32'h0000_0000);
    wb(1'b1, `BFP_CTRL, 32'h0000_0009);
    repeat (3) @(posedge clock);
    chk({31'h0000_0000, prg_start}, 32'h0000_0001);
    wait_for(force_active, 1'b0);
    $display("force done");
    // magnitude difference of a distortion value and a virtual input
    meas[40] <= 16'h00C8;
    wb(1'b1, `BFP_PRG_CFG, 32'h0123_281F);
    wait_for(prg_start, 1'b1);
    chk({31'h0000_0000, prg_trip}, 32'h0000_0000);
    // both stages blocked report blocked status
    block_bf <= 1'b1;
    block_prg <= 1'b1;
    repeat (2) @(posedge clock);
    wb(1'b0, `BFP_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    $display("difference and blocking done");
    conclude();
  end
endmodule
